// ### rtl/winding_pkg.sv
// Purpose: Shared constants and carrier types for the winding length and speed source block.
// Assumes: Registers are reached over a plain address/strobe port with one-cycle read latency.
// Notes: Offsets are word indices on the plain register port.
package winding_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // Register offsets.
  localparam logic [3:0] OFF_THRESHOLD = 4'h0;
  localparam logic [3:0] OFF_UNIT = 4'h1;
  localparam logic [3:0] OFF_STORED = 4'h2;
  localparam logic [3:0] OFF_SPEED_SRC = 4'h3;
  localparam logic [3:0] OFF_LINE_SRC = 4'h4;
  localparam logic [3:0] OFF_DIAM_STORE = 4'h5;
  localparam logic [3:0] OFF_CTRL_FUNC = 4'h6;
  localparam logic [3:0] OFF_TERM_FOUR = 4'h7;
  localparam logic [3:0] OFF_TERM_ONE = 4'h8;
  localparam logic [3:0] OFF_GAIN_TWO = 4'h9;
  localparam logic [3:0] OFF_GAIN_THREE = 4'ha;
  localparam logic [3:0] OFF_GAIN_FOUR = 4'hb;
  localparam logic [3:0] OFF_STATUS = 4'hc;
  localparam logic [3:0] OFF_OUT_SEL = 4'hd;
  // Reset values.
  localparam logic [15:0] RST_THRESHOLD = 16'h03e8;
  localparam logic [1:0] RST_UNIT = 2'h0;
  localparam logic [15:0] RST_STORED = 16'h0000;
  localparam logic [2:0] RST_SPEED_SRC = 3'h0;
  localparam logic [15:0] RST_TERM_FOUR = 16'h270f;
  localparam logic [15:0] RST_TERM_ONE = 16'h270f;
  localparam logic [15:0] RST_OUT_SEL = 16'h0035;
  localparam logic [2:0] RST_LINE_SRC = 3'h0;
  localparam logic RST_DIAM_STORE = 1'b0;
  localparam logic [15:0] RST_CTRL_FUNC = 16'h0000;
  localparam logic [15:0] RST_GAIN = 16'h0000;
  // Setting codes.
  localparam logic [15:0] LEN_MAX = 16'h270f;
  localparam logic [15:0] CODE_CTRL_A = 16'h0028;
  localparam logic [15:0] CODE_CTRL_B = 16'h0029;
  localparam logic [15:0] CODE_T4_COMP = 16'h0001;
  localparam logic [15:0] CODE_T4_TAPER = 16'h0002;
  localparam logic [15:0] CODE_T4_OFF = 16'h270f;
  localparam logic [2:0] SRC_CODE_PULSE = 3'h1;
  localparam logic [15:0] CODE_REACH_POS = 16'h0035;
  localparam logic [15:0] CODE_REACH_NEG = 16'h0099;
  localparam logic [2:0] LINE_SRC_MIN = 3'h1;
  // Status field positions.
  localparam int ST_REACHED = 0;
  localparam int ST_TRACK = 1;
  localparam int ST_DANCER = 2;
  localparam int ST_COMP = 3;
  localparam int ST_SEL_EN = 4;
  // Length unit meters per count, per unit code.
  localparam logic [9:0] UNIT_M0 = 10'h001;
  localparam logic [9:0] UNIT_M1 = 10'h00a;
  localparam logic [9:0] UNIT_M2 = 10'h064;
  localparam logic [9:0] UNIT_M3 = 10'h3e8;

  // Main speed source, in priority order.
  typedef enum logic [2:0] {SRC_NONE, SRC_JOG, SRC_PRIO_TWO, SRC_MULTI, SRC_PRIO_FOUR,
    SRC_ANALOG} main_src_t;

  // Gain choice for the analog main speed.
  typedef enum logic [1:0] {GAIN_OWN, GAIN_TWO, GAIN_THREE, GAIN_FOUR} gain_sel_t;

  // Register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Terminal inputs from the external controller.
  typedef struct packed {
    logic jog;
    logic priority_two_in;
    logic multi;
    logic priority_four_in;
    logic analog;
    logic gain_sel_lo_in;
    logic gain_sel_hi_in;
    logic length_clear_in;
    logic diameter_clear_in;
    logic diameter_store;
    logic meter_tick;
  } term_in_t;

  // Speed selection results.
  typedef struct packed {
    main_src_t src;
    gain_sel_t gain;
    logic [15:0] gain_value;
    logic comp_en;
    logic dancer_en;
  } speed_out_t;
endpackage : winding_pkg

// ### rtl/unit_scaler.sv
// Purpose: Counts metres of material and emits one pulse per length unit.
// Assumes: Meter ticks arrive one per metre, synchronous to clock.
// Notes: The scaler restarts when the unit changes, while the clear is held or while tracking is idle.
`timescale 1ns/1ps
module unit_scaler (
  input wire logic clock, // Block clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic [1:0] unitSel, // Length unit code.
  input wire logic restart, // Drops partial units.
  input wire logic meterTick, // One metre passed.
  output logic unitTick // One length unit passed.
);
  import winding_pkg::*;
  logic [9:0] metersPerUnit;
  logic [9:0] meterCnt_ff;

  // Meters needed for one stored count.
  always_comb begin
    case (unitSel)
      2'h0: metersPerUnit = UNIT_M0;
      2'h1: metersPerUnit = UNIT_M1;
      2'h2: metersPerUnit = UNIT_M2;
      default: metersPerUnit = UNIT_M3;
    endcase
  end

  // Partial-unit counter.
  always_ff @(posedge clock) begin
    if (!rst_n || restart) begin
      meterCnt_ff <= 10'h000;
    end else if (meterTick) begin
      meterCnt_ff <= (meterCnt_ff + 10'h001 >= metersPerUnit) ? 10'h000 : meterCnt_ff + 10'h001;
    end
  end

  assign unitTick = meterTick && (meterCnt_ff + 10'h001 >= metersPerUnit);
endmodule : unit_scaler

// ### rtl/winding_length_and_speed_source.sv
// Purpose: Length tracking, length-reached output and main speed source selection.
// Assumes: Terminal inputs are asynchronous and pass two flip-flops first.
// Notes: Holds the setting registers behind a plain register port.
// How it works
// RQ1: Tracking only when line source is 1 to 7.
// RQ2: Unit code scales threshold and stored length.
// RQ3: Reached output when length exceeds threshold.
// RQ4: Diameter store selection 1 stores length too.
// RQ5: Stored length readable and overwritable, 0 to 9999.
// RQ6: Length-clear input zeroes the stored length.
// RQ7: Diameter clear leaves the stored length alone.
// RQ8: Reached output polarity set by code 53/153.
// RQ9: Speed source selector accepts codes 0 to 7.
// RQ10: Priority jog, two, multi, four, analog.
// RQ11: Line speed source excluded from main speed.
// RQ12: Multi-speed keeps dancer control active.
// RQ13: Jog disables dancer and diameter compensation.
// RQ14: Main selection enabled only for 40/41.
// RQ15: Terminal-4 compensation only when setting is 1.
// RQ16: Controller waits 20 ms when switching modes; the bench model waits only SWITCH_GAP (8) clocks.
// RQ17: Two inputs pick one of four gains.
// RQ18: User disables terminal 1 with 9999; the block only stores termOne_ff and reads it back.
// RQ19: Terminal-4 codes 1, 2 and 9999.
// RQ20: Reached output drops once length is cleared.
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
module winding_length_and_speed_source (
  input wire logic clock, // Block clock, 250 MHz.
  input wire logic rst_n, // Synchronous reset, active low.
  input winding_pkg::reg_req_t regReq, // Register request.
  output logic [15:0] regRdata, // Read data, one cycle after read strobe.
  input winding_pkg::term_in_t termIn, // Terminal inputs, asynchronous.
  input wire logic analogIsLineSrc, // Analog input is the line speed input.
  input wire logic pulseIsLineSrc, // Pulse input is the line speed input.
  output logic lengthReachedOut, // Length-reached terminal level.
  output logic [15:0] storedLengthOut, // Held length, in units.
  output logic lengthTrackingOn, // Length tracking active.
  output winding_pkg::speed_out_t speedOut // Main speed choice.
);
  import winding_pkg::*;

  // Terminal levels take two clocks through the synchroniser, so a pin
  // change shows on the outputs three clocks later.
  // A register write takes effect on the clock after its strobe.

  // Setting registers, one per software setting.
  logic [15:0] threshold_ff;
  logic [1:0] unit_ff;
  logic [15:0] stored_ff;
  logic [15:0] storedSnap_ff;
  logic [2:0] speedSrc_ff;
  logic [2:0] lineSrc_ff;
  logic diamStore_ff;
  logic [15:0] ctrlFunc_ff;
  logic [15:0] termFour_ff;
  logic [15:0] termOne_ff;
  logic [15:0] gainTwo_ff;
  logic [15:0] gainThree_ff;
  logic [15:0] gainFour_ff;
  logic [15:0] outSel_ff;
  // Read data register.
  logic [15:0] rdata_ff;
  // Terminal synchroniser stages.
  term_in_t syncA_ff;
  term_in_t syncB_ff;
  // Store edge detector, reached flag and terminal level.
  logic storePrev_ff;
  logic reached_ff;
  logic lengthOut_ff;
  // Registered speed choice.
  speed_out_t speed_ff;
  // Combinational helpers.
  logic unitTick;
  logic tracking;
  logic storeEdge;
  logic wrEn;
  logic [15:0] nxt_stored;
  main_src_t nxt_src;
  gain_sel_t nxt_gain;
  logic [15:0] nxt_gainValue;
  // Write qualifiers, unit change detector and status helpers.
  logic [1:0] unitPrev_ff;
  logic unitChanged;
  logic reachNow;
  logic thresholdOk;
  logic storedOk;
  logic termFourOk;
  logic outSelOk;
  logic jogIsLine;
  logic [15:0] statusWord;

  assign wrEn = regReq.wr;

  // Accepted setting values; a refused write keeps the old value.
  assign thresholdOk = regReq.wdata <= LEN_MAX; // see RQ3
  assign storedOk = regReq.wdata <= LEN_MAX; // see RQ5
  assign termFourOk = regReq.wdata == CODE_T4_COMP || regReq.wdata == CODE_T4_TAPER
    || regReq.wdata == CODE_T4_OFF; // see RQ19
  assign outSelOk = regReq.wdata == CODE_REACH_POS
    || regReq.wdata == CODE_REACH_NEG; // see RQ8

  // Two-flop synchroniser for terminal inputs.
  // Only the second stage is read by the logic.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      syncA_ff <= '0;
      syncB_ff <= '0;
    end else begin
      syncA_ff <= termIn;
      syncB_ff <= syncA_ff;
    end
  end

  // Length tracking is offered only with a line speed input chosen.
  assign tracking = (lineSrc_ff >= LINE_SRC_MIN); // see RQ1

  // A unit change drops the partial unit, so counting restarts cleanly.
  assign unitChanged = unit_ff != unitPrev_ff; // see RQ2
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      unitPrev_ff <= RST_UNIT;
    end else begin
      unitPrev_ff <= unit_ff;
    end
  end

  // Unit scaler converts metres into stored counts.
  // Clear, idle tracking or a new unit restart its partial count.
  unit_scaler scaler (
    .clock(clock),
    .rst_n(rst_n),
    .unitSel(unit_ff), // see RQ2
    .restart(syncB_ff.length_clear_in || !tracking || unitChanged),
    .meterTick(syncB_ff.meter_tick && tracking),
    .unitTick(unitTick)
  );

  // Length settings written by software.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      threshold_ff <= RST_THRESHOLD;
      unit_ff <= RST_UNIT;
      lineSrc_ff <= RST_LINE_SRC;
      diamStore_ff <= RST_DIAM_STORE;
      outSel_ff <= RST_OUT_SEL;
    end else if (wrEn) begin
      case (regReq.addr)
        OFF_THRESHOLD: begin
          if (thresholdOk) begin
            threshold_ff <= regReq.wdata; // see RQ3
          end
        end
        OFF_UNIT: unit_ff <= regReq.wdata[1:0]; // see RQ2
        OFF_LINE_SRC: lineSrc_ff <= regReq.wdata[2:0]; // see RQ1
        OFF_DIAM_STORE: diamStore_ff <= regReq.wdata[0]; // see RQ4
        OFF_OUT_SEL: begin
          if (outSelOk) begin
            outSel_ff <= regReq.wdata; // see RQ8
          end
        end
        default: ;
      endcase
    end
  end

  // Speed source settings written by software.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      speedSrc_ff <= RST_SPEED_SRC;
      ctrlFunc_ff <= RST_CTRL_FUNC;
      termFour_ff <= RST_TERM_FOUR;
      termOne_ff <= RST_TERM_ONE;
      gainTwo_ff <= RST_GAIN;
      gainThree_ff <= RST_GAIN;
      gainFour_ff <= RST_GAIN;
    end else if (wrEn) begin
      case (regReq.addr)
        OFF_SPEED_SRC: speedSrc_ff <= regReq.wdata[2:0]; // see RQ9
        OFF_CTRL_FUNC: ctrlFunc_ff <= regReq.wdata; // see RQ14
        OFF_TERM_FOUR: begin
          // Only the compensation, taper and disabled codes are accepted.
          if (termFourOk) begin
            termFour_ff <= regReq.wdata; // see RQ19
          end
        end
        OFF_TERM_ONE: termOne_ff <= regReq.wdata;
        OFF_GAIN_TWO: gainTwo_ff <= regReq.wdata; // see RQ17
        OFF_GAIN_THREE: gainThree_ff <= regReq.wdata;
        OFF_GAIN_FOUR: gainFour_ff <= regReq.wdata;
        default: ;
      endcase
    end
  end

  // Next held length: clear wins, then software write, then counting.
  // Counting stops at the top of the range instead of wrapping.
  always_comb begin
    nxt_stored = stored_ff;
    if (syncB_ff.length_clear_in) begin
      nxt_stored = 16'h0000; // see RQ6
    end else if (wrEn && regReq.addr == OFF_STORED && storedOk) begin
      nxt_stored = regReq.wdata; // see RQ5
    end else if (unitTick && stored_ff < LEN_MAX) begin
      nxt_stored = stored_ff + 16'h0001;
    end
  end

  // Held length; the diameter clear input plays no part here.
  // Only the length clear terminal or a write can lower it.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stored_ff <= RST_STORED; // see RQ7
    end else begin
      stored_ff <= nxt_stored;
    end
  end

  // Snapshot of the length taken on the diameter store event.
  // The edge detector idles low, matching the released terminal.
  assign storeEdge = syncB_ff.diameter_store && !storePrev_ff;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      storePrev_ff <= 1'b0;
      storedSnap_ff <= 16'h0000;
    end else begin
      storePrev_ff <= syncB_ff.diameter_store;
      if (storeEdge && diamStore_ff) begin
        storedSnap_ff <= stored_ff; // see RQ4
      end
    end
  end

  // Length is over the threshold while tracking is offered.
  assign reachNow = tracking && (nxt_stored > threshold_ff); // see RQ3

  // Length-reached flag follows the comparison, so a clear drops it.
  // It is taken from the next length so flag and length move together.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reached_ff <= 1'b0;
      lengthOut_ff <= 1'b0;
    end else begin
      reached_ff <= reachNow; // see RQ20
      lengthOut_ff <= (outSel_ff == CODE_REACH_NEG) ? !reachNow : reachNow; // see RQ8
    end
  end

  // Jog carries the line speed pulse when that input serves both uses.
  assign jogIsLine = pulseIsLineSrc && speedSrc_ff == SRC_CODE_PULSE; // see RQ11

  // Main speed source by fixed priority, skipping the line speed input.
  // Without the dancer control function code nothing is selected.
  always_comb begin
    nxt_src = SRC_NONE;
    if (ctrlFunc_ff == CODE_CTRL_A || ctrlFunc_ff == CODE_CTRL_B) begin // see RQ14
      if (syncB_ff.jog && !jogIsLine) begin
        nxt_src = SRC_JOG; // see RQ10 see RQ11
      end else if (syncB_ff.priority_two_in) begin
        nxt_src = SRC_PRIO_TWO;
      end else if (syncB_ff.multi) begin
        nxt_src = SRC_MULTI;
      end else if (syncB_ff.priority_four_in) begin
        nxt_src = SRC_PRIO_FOUR;
      end else if (syncB_ff.analog && !analogIsLineSrc) begin
        nxt_src = SRC_ANALOG; // see RQ11
      end
    end
  end

  // Gain pick from the two select inputs.
  // The own gain of the terminal is applied outside, so its value reads zero.
  always_comb begin
    case ({syncB_ff.gain_sel_hi_in, syncB_ff.gain_sel_lo_in})
      2'b00: nxt_gain = GAIN_OWN; // see RQ17
      2'b01: nxt_gain = GAIN_TWO;
      2'b10: nxt_gain = GAIN_THREE;
      default: nxt_gain = GAIN_FOUR;
    endcase
    case (nxt_gain)
      GAIN_TWO: nxt_gainValue = gainTwo_ff;
      GAIN_THREE: nxt_gainValue = gainThree_ff;
      GAIN_FOUR: nxt_gainValue = gainFour_ff;
      default: nxt_gainValue = 16'h0000;
    endcase
  end

  // Registered speed choice; jog stops dancer control, multi-speed does not.
  // Compensation also needs the terminal-4 compensation code.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      speed_ff <= '0;
    end else begin
      speed_ff.src <= nxt_src;
      speed_ff.gain <= nxt_gain;
      speed_ff.gain_value <= nxt_gainValue;
      speed_ff.dancer_en <= !syncB_ff.jog; // see RQ12 see RQ13
      speed_ff.comp_en <= !syncB_ff.jog && (termFour_ff == CODE_T4_COMP); // see RQ15 see RQ13
    end
  end

  // Status word, one bit per field position.
  // Bits above the fields read as zero.
  always_comb begin
    statusWord = 16'h0000;
    statusWord[ST_REACHED] = reached_ff; // see RQ3
    statusWord[ST_TRACK] = tracking; // see RQ1
    statusWord[ST_DANCER] = speed_ff.dancer_en;
    statusWord[ST_COMP] = speed_ff.comp_en;
    statusWord[ST_SEL_EN] = speed_ff.src != SRC_NONE;
  end

  // Read data, valid the cycle after the read strobe.
  // Between reads the port shows zero, so a stale word is never seen.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_ff <= 16'h0000;
    end else if (regReq.rd) begin
      case (regReq.addr)
        OFF_THRESHOLD: rdata_ff <= threshold_ff;
        OFF_UNIT: rdata_ff <= {14'h0000, unit_ff};
        OFF_STORED: rdata_ff <= stored_ff; // see RQ5
        OFF_SPEED_SRC: rdata_ff <= {13'h0000, speedSrc_ff};
        OFF_LINE_SRC: rdata_ff <= {13'h0000, lineSrc_ff};
        OFF_DIAM_STORE: rdata_ff <= {15'h0000, diamStore_ff};
        OFF_CTRL_FUNC: rdata_ff <= ctrlFunc_ff;
        OFF_TERM_FOUR: rdata_ff <= termFour_ff;
        OFF_TERM_ONE: rdata_ff <= termOne_ff;
        OFF_GAIN_TWO: rdata_ff <= gainTwo_ff;
        OFF_GAIN_THREE: rdata_ff <= gainThree_ff;
        OFF_GAIN_FOUR: rdata_ff <= gainFour_ff;
        OFF_STATUS: rdata_ff <= statusWord;
        OFF_OUT_SEL: rdata_ff <= outSel_ff;
        default: rdata_ff <= storedSnap_ff;
      endcase
    end else begin
      rdata_ff <= 16'h0000;
    end
  end

  // Outputs come straight from their registers, except lengthTrackingOn, which is decoded from lineSrc_ff.
  assign regRdata = rdata_ff;
  assign lengthReachedOut = lengthOut_ff;
  assign storedLengthOut = stored_ff;
  assign lengthTrackingOn = tracking;
  assign speedOut = speed_ff;
endmodule : winding_length_and_speed_source

// ### verif/winding_sva.sv
// Purpose: Port checks for the winding length and speed source block.
// Assumes: Settings reach the block only over the register port.
// Notes: Helpers mirror line source and output polarity writes.
`timescale 1ns/1ps
module winding_sva (
  input wire logic clock, // Clock.
  input wire logic rst_n, // Reset.
  input winding_pkg::reg_req_t regReq, // Requests.
  input wire logic [15:0] regRdata, // Read data.
  input winding_pkg::term_in_t termIn, // Terminals.
  input wire logic analogIsLineSrc, // Analog is line source.
  input wire logic pulseIsLineSrc, // Pulse is line source.
  input wire logic lengthReachedOut, // Reached level.
  input wire logic [15:0] storedLengthOut, // Held length.
  input wire logic lengthTrackingOn, // Tracking.
  input winding_pkg::speed_out_t speedOut // Speed choice.
);
  import winding_pkg::*;
  logic [2:0] lineSrc_ff;
  logic lineKnown_ff;
  logic outNeg_ff;
  // Mirrors the line source and the accepted output polarity codes.
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lineKnown_ff <= 1'b0;
      lineSrc_ff <= 3'h0;
      outNeg_ff <= 1'b0;
    end else if (regReq.wr) begin
      if (regReq.addr == OFF_LINE_SRC) begin
        lineKnown_ff <= 1'b1;
        lineSrc_ff <= regReq.wdata[2:0];
      end
      if (regReq.addr == OFF_OUT_SEL && (regReq.wdata == CODE_REACH_POS ||
          regReq.wdata == CODE_REACH_NEG)) begin
        outNeg_ff <= regReq.wdata == CODE_REACH_NEG;
      end
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_clear_zero_len: assert property (
    termIn.length_clear_in [*4] |-> storedLengthOut == 16'h0) else $error("length kept");
  a_clear_drop_reach: assert property (
    termIn.length_clear_in [*5] |-> lengthReachedOut == $past(outNeg_ff))
    else $error("reached kept");
  a_track_by_line: assert property (
    lineKnown_ff |-> lengthTrackingOn == (lineSrc_ff != 3'h0)) else $error("tracking wrong");
  a_idle_no_reach: assert property (
    (!lengthTrackingOn) [*2] |-> lengthReachedOut == $past(outNeg_ff))
    else $error("reached while idle");
  a_jog_no_dancer: assert property (
    (termIn.jog && !pulseIsLineSrc) [*4] |-> !speedOut.dancer_en && !speedOut.comp_en)
    else $error("dancer during jog");
  a_gain_follows: assert property (
    ($stable(termIn.gain_sel_lo_in) && $stable(termIn.gain_sel_hi_in)) [*4] |->
    speedOut.gain == gain_sel_t'({termIn.gain_sel_hi_in, termIn.gain_sel_lo_in}))
    else $error("gain wrong");
  a_no_line_analog: assert property (
    analogIsLineSrc [*2] |-> speedOut.src != SRC_ANALOG) else $error("line source used");
  a_rd_idle_zero: assert property (
    !$past(regReq.rd) |-> regRdata == 16'h0) else $error("stray read data");
  a_len_readback: assert property (
    $past(regReq.rd && regReq.addr == OFF_STORED) |-> regRdata == $past(storedLengthOut))
    else $error("read back wrong");
  a_len_in_range: assert property (
    storedLengthOut <= LEN_MAX) else $error("length out of range");
  c_reached: cover property (lengthReachedOut && lengthTrackingOn);
  c_jog: cover property (speedOut.src == SRC_JOG);
  c_gain_four: cover property (speedOut.gain == GAIN_FOUR);
endmodule : winding_sva

bind winding_length_and_speed_source winding_sva chk_u (.clock, .rst_n, .regReq,
  .regRdata, .termIn, .analogIsLineSrc, .pulseIsLineSrc, .lengthReachedOut,
  .storedLengthOut, .lengthTrackingOn, .speedOut);

// ### verif/term_driver.sv
// Purpose: External controller that drives the terminal inputs.
// Assumes: Levels change by non-blocking assignment at a rising edge.
// Notes: Each level set, and each whole run of metre ticks, is followed by a shortened settling gap.
`timescale 1ns/1ps
module term_driver #(
  parameter int SWITCH_GAP = 8 // Cycles standing in for the mode settle time.
) (
  input wire logic clock, // Clock.
  output winding_pkg::term_in_t termOut // Terminal levels.
);
  import winding_pkg::*;
  // Terminals start released.
  initial termOut = '0;
  // Sets all terminal levels, then leaves time for the block to settle.
  task automatic put(input term_in_t v);
    @(posedge clock);
    termOut <= v;
    repeat (SWITCH_GAP) @(posedge clock);
    #1;
  endtask : put
  // Sends metre ticks with a low cycle between them.
  task automatic meters(input int n);
    repeat (n) begin
      @(posedge clock);
      termOut.meter_tick <= 1'b1;
      @(posedge clock);
      termOut.meter_tick <= 1'b0;
    end
    repeat (SWITCH_GAP) @(posedge clock);
    #1;
  endtask : meters
endmodule : term_driver

// ### verif/test_winding_length_and_speed_source.sv
// Purpose: Self-checking bench for the winding length and speed source block.
// Assumes: Terminal traffic comes from the term_driver model.
// Notes: Terminal settling waits come from the model's gap; register writes use a two-cycle pause.
`timescale 1ns/1ps
module test_winding_length_and_speed_source;
  import winding_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  reg_req_t regReq = '0;
  logic analogIsLineSrc = 1'b0;
  logic pulseIsLineSrc = 1'b0;
  term_in_t termIn;
  logic [15:0] regRdata;
  logic lengthReachedOut;
  logic [15:0] storedLengthOut;
  logic lengthTrackingOn;
  speed_out_t speedOut;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  term_driver ctl_u (.clock(clock), .termOut(termIn));
  winding_length_and_speed_source dut_u (.clock(clock), .rst_n(rst_n), .regReq(regReq),
    .regRdata(regRdata), .termIn(termIn), .analogIsLineSrc(analogIsLineSrc),
    .pulseIsLineSrc(pulseIsLineSrc), .lengthReachedOut(lengthReachedOut),
    .storedLengthOut(storedLengthOut), .lengthTrackingOn(lengthTrackingOn),
    .speedOut(speedOut));
  // Free-running clock.
  initial forever #2 clock = ~clock;
  task automatic end_of_test;
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test
  // Cuts a hang short.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      end_of_test;
    end
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    regReq.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clock);
    regReq <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    regReq.rd <= 1'b0;
    #1 cmp(regRdata, exp);
  endtask : rd
  task automatic pause;
    repeat (2) @(posedge clock);
    #1;
  endtask : pause
  task automatic t_regs;
    rd(OFF_THRESHOLD, 16'h03e8);
    rd(OFF_UNIT, 16'h0);
    rd(OFF_STORED, 16'h0);
    rd(OFF_SPEED_SRC, 16'h0);
    wr(4'hf, 16'h1234);
    rd(OFF_THRESHOLD, 16'h03e8);
    wr(OFF_STORED, 16'h2710);
    rd(OFF_STORED, 16'h0);
    wr(OFF_STORED, LEN_MAX);
    rd(OFF_STORED, LEN_MAX);
    wr(OFF_SPEED_SRC, 16'h7);
    rd(OFF_SPEED_SRC, 16'h7);
    wr(OFF_THRESHOLD, LEN_MAX);
  endtask : t_regs
  task automatic t_units;
    logic [15:0] m [4] = '{16'h1, 16'ha, 16'h64, 16'h3e8};
    wr(OFF_LINE_SRC, 16'h1);
    for (int u = 0; u < 4; u++) begin
      wr(OFF_UNIT, 16'(u));
      wr(OFF_STORED, 16'h0);
      ctl_u.meters(int'(m[u]) - 1);
      cmp(storedLengthOut, 16'h0);
      ctl_u.meters(1);
      cmp(storedLengthOut, 16'h1);
    end
    wr(OFF_UNIT, 16'h0);
    wr(OFF_LINE_SRC, 16'h0);
    ctl_u.meters(2);
    cmp({15'h0, lengthTrackingOn}, 16'h0);
    cmp(storedLengthOut, 16'h1);
  endtask : t_units
  task automatic t_reach;
    wr(OFF_LINE_SRC, 16'h1);
    wr(OFF_THRESHOLD, 16'h3);
    wr(OFF_STORED, 16'h0);
    ctl_u.meters(3);
    cmp({15'h0, lengthReachedOut}, 16'h0);
    ctl_u.meters(1);
    cmp({15'h0, lengthReachedOut}, 16'h1);
    rd(OFF_STATUS, 16'h0007);
    ctl_u.put(term_in_t'(11'h004));
    cmp(storedLengthOut, 16'h4);
    wr(OFF_OUT_SEL, CODE_REACH_NEG);
    wr(OFF_OUT_SEL, 16'h0007);
    pause;
    cmp({15'h0, lengthReachedOut}, 16'h0);
    ctl_u.put(term_in_t'(11'h008));
    cmp(storedLengthOut, 16'h0);
    cmp({15'h0, lengthReachedOut}, 16'h1);
    wr(OFF_OUT_SEL, CODE_REACH_POS);
    pause;
    cmp({15'h0, lengthReachedOut}, 16'h0);
  endtask : t_reach
  task automatic t_speed;
    wr(OFF_CTRL_FUNC, CODE_CTRL_A);
    wr(OFF_TERM_FOUR, CODE_T4_COMP);
    wr(OFF_TERM_ONE, 16'h270f);
    for (int i = 0; i < 6; i++) begin
      ctl_u.put(term_in_t'({5'h1f >> i, 6'h0}));
      cmp(16'(speedOut.src), (i < 5) ? 16'(i + 1) : 16'h0);
    end
    ctl_u.put(term_in_t'(11'h400));
    cmp(16'({speedOut.dancer_en, speedOut.comp_en}), 16'h0);
    ctl_u.put(term_in_t'(11'h100));
    cmp({15'h0, speedOut.dancer_en}, 16'h1);
    wr(OFF_CTRL_FUNC, 16'h0027);
    pause;
    cmp(16'(speedOut.src), 16'h0);
    wr(OFF_CTRL_FUNC, CODE_CTRL_B);
    pause;
    cmp(16'(speedOut.src), 16'(SRC_MULTI));
    ctl_u.put(term_in_t'(11'h040));
    cmp({15'h0, speedOut.comp_en}, 16'h1);
    wr(OFF_TERM_FOUR, 16'h0005);
    pause;
    cmp({15'h0, speedOut.comp_en}, 16'h1);
    wr(OFF_TERM_FOUR, 16'h0002);
    pause;
    cmp({15'h0, speedOut.comp_en}, 16'h0);
    for (int g = 1; g < 4; g++) wr(4'(OFF_GAIN_TWO + g - 1), 16'(16'h0100 + g));
    for (int g = 0; g < 4; g++) begin
      ctl_u.put(term_in_t'({5'h01, g[0], g[1], 4'h0}));
      cmp(16'(speedOut.gain), 16'(g));
      if (g > 0) cmp(speedOut.gain_value, 16'(16'h0100 + g));
    end
    analogIsLineSrc <= 1'b1;
    ctl_u.put(term_in_t'(11'h040));
    cmp(16'(speedOut.src), 16'h0);
    analogIsLineSrc <= 1'b0;
    wr(OFF_SPEED_SRC, 16'h1);
    pulseIsLineSrc <= 1'b1;
    ctl_u.put(term_in_t'(11'h500));
    cmp(16'(speedOut.src), 16'(SRC_MULTI));
    pulseIsLineSrc <= 1'b0;
  endtask : t_speed
  task automatic t_store;
    wr(OFF_DIAM_STORE, 16'h1);
    wr(OFF_STORED, 16'h7);
    ctl_u.put(term_in_t'(11'h002));
    wr(OFF_STORED, 16'h9);
    rd(4'he, 16'h7);
  endtask : t_store
  // Main sequence.
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    t_regs;
    t_units;
    t_reach;
    t_speed;
    t_store;
    end_of_test;
  end
endmodule : test_winding_length_and_speed_source
